// ==== logic/aos_buf.sv ====
// Two-entry sample buffer with valid and ready on both sides.
`timescale 1ns/1ns
module aos_buf (
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire logic   cken,
	aos_stream_if.snk   fill,
	aos_stream_if.src   drain
);
	typedef struct packed {
		logic [aos_pkg::BUF_DEPTH-1:0][aos_pkg::RES_BITS-1:0] mem;
		logic                                                 wr_idx;
		logic                                                 rd_idx;
		logic [1:0]                                           count;
		logic                                                 rdy;
	} aos_buf_s;

	aos_buf_s buf_reg;
	aos_buf_s buf_next;
	logic     push;
	logic     pop;

	always_comb begin
		buf_next = buf_reg;
		push = fill.valid && buf_reg.rdy;
		pop = drain.ready && (buf_reg.count != 2'h0);
		if (push) begin
			buf_next.mem[buf_reg.wr_idx] = fill.data;
			buf_next.wr_idx = ~buf_reg.wr_idx;
		end
		if (pop) begin
			buf_next.rd_idx = ~buf_reg.rd_idx;
		end
		buf_next.count = 2'(buf_reg.count + {1'h0, push} - {1'h0, pop});
		// Ready is registered so the source sees a plain flop; it may lag a pop by one cycle.
		buf_next.rdy = (buf_next.count != 2'(aos_pkg::BUF_DEPTH));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_reg <= '0;
			buf_reg.rdy <= 1'h1;
		end else if (cken) begin
			buf_reg <= buf_next;
		end
	end

	assign fill.ready = buf_reg.rdy;
	assign drain.valid = (buf_reg.count != 2'h0);
	assign drain.data = buf_reg.mem[buf_reg.rd_idx];
endmodule : aos_buf

// ==== logic/aos_pkg.sv ====
// Constants, types and register map of the converter serial port sequencer.
package aos_pkg;
	localparam int unsigned RES_BITS = 12;
	localparam int unsigned CFG_BITS = 3;
	localparam int unsigned CONV_CYCLES = 12;
	localparam int unsigned BUF_DEPTH = 2;
	localparam int unsigned APB_AW = 8;

	localparam logic [3:0] CFG_IDX_SGL = 4'h0;
	localparam logic [3:0] CFG_IDX_ODD = 4'h1;
	localparam logic [3:0] CFG_IDX_ORDER = 4'h2;
	localparam logic [3:0] CFG_DONE = 4'h3;
	localparam logic [3:0] CONV_LAST = 4'hB;
	localparam logic [3:0] DATA_LAST = 4'hB;

	localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] OFF_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] OFF_RESULT = 8'h08;

	localparam int unsigned CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'h1;
	localparam int unsigned ST_STATE_LSB = 0;
	localparam int unsigned ST_SGL_BIT = 4;
	localparam int unsigned ST_ODD_BIT = 5;
	localparam int unsigned ST_ORDER_BIT = 6;
	localparam int unsigned ST_UNDERRUN_BIT = 7;

	// Synchroniser bit order: select line, shift clock, serial input.
	localparam int unsigned PIN_SEL = 0;
	localparam int unsigned PIN_CLK = 1;
	localparam int unsigned PIN_DIN = 2;
	localparam logic [2:0] PIN_RST = 3'h1;

	localparam logic [1:0] MUX_GND = 2'h0;
	localparam logic [1:0] MUX_CH0 = 2'h1;
	localparam logic [1:0] MUX_CH1 = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_START = 3'h1,
		ST_CFG   = 3'h3,
		ST_CONV  = 3'h2,
		ST_DATA  = 3'h6,
		ST_FILL  = 3'h7
	} aos_state_e;

	typedef logic [RES_BITS-1:0] aos_word_t;
endpackage : aos_pkg

// ==== logic/aos_seq.sv ====
// Serial port and conversion sequencer of the two-channel sampling converter.
// Summary of operation
// - Order bit one: result MSB first, then zeros.
// - Zero fill continues for every further clock.
// - Order bit zero: MSB first, then LSB first.
// - Result is unipolar straight binary only.
// - Drive line low on fourth falling edge.
// - Active only while select is low.
// - Comparator powers down when conversion ends.
// - Clock and input ignored while deselected.
// - Sample window opens before order bit.
// - Falling edge after order bit starts hold.
// - Conversion takes exactly twelve clock cycles.
// - Change data on falling, sample on rising.
// - Skip zeros, start bit, three config bits.
// - One null bit precedes the result.
// - Config bits choose the input pair.
`timescale 1ns/1ns
module aos_seq (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              cken,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [aos_pkg::APB_AW-1:0]        paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	input  wire logic                              select_n_shutdown,
	input  wire logic                              shift_clk,
	input  wire logic                              data_in,
	output logic                                   data_out,
	output logic                                   data_oe,
	input  wire logic [aos_pkg::RES_BITS-1:0]      sample_data,
	input  wire logic                              sample_valid,
	output logic                                   sample_ready,
	output logic                                   sample_window,
	output logic                                   hold,
	output logic                                   comparator_power,
	output logic      [1:0]                        mux_pos_sel,
	output logic      [1:0]                        mux_neg_sel
);
	typedef struct packed {
		aos_pkg::aos_state_e state;
		logic [3:0]          cnt;
		logic                single_ended_select;
		logic                odd_sign;
		logic                bit_order_select;
		aos_pkg::aos_word_t  shift;
		aos_pkg::aos_word_t  word;
		aos_pkg::aos_word_t  last_word;
		logic                clk_d;
		logic                dout;
		logic                doe;
		logic                win;
		logic                hold;
		logic                comp_pwr;
		logic [1:0]          pos_sel;
		logic [1:0]          neg_sel;
		logic                pop;
		logic                underrun;
		logic                port_en;
		logic                pready;
		logic                pslverr;
		logic [31:0]         prdata;
	} aos_seq_s;

	aos_seq_s seq_reg;
	aos_seq_s seq_next;
	logic [2:0] pins;
	logic       s_sel_n;
	logic       s_clk;
	logic       s_din;
	logic       rise;
	logic       fall;
	logic       setup;
	logic       access;

	aos_stream_if fill_if ();
	aos_stream_if drain_if ();

	assign fill_if.data = sample_data;
	assign fill_if.valid = sample_valid;
	assign drain_if.ready = seq_reg.pop;

	aos_sync u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.cken     (cken),
		.pin_in   ({data_in, shift_clk, select_n_shutdown}),
		.pin_sync (pins)
	);

	aos_buf u_buf (
		.pclk    (pclk),
		.presetn (presetn),
		.cken    (cken),
		.fill    (fill_if.snk),
		.drain   (drain_if.src)
	);

	assign s_sel_n = pins[aos_pkg::PIN_SEL];
	assign s_clk = pins[aos_pkg::PIN_CLK];
	assign s_din = pins[aos_pkg::PIN_DIN];

	always_comb begin
		seq_next = seq_reg;
		seq_next.pop = 1'h0;
		seq_next.clk_d = s_clk;
		rise = s_clk && !seq_reg.clk_d;
		fall = !s_clk && seq_reg.clk_d;
		setup = psel && !penable;
		access = psel && penable && seq_reg.pready;

		// Read data is latched in the setup cycle so the bus outputs stay plain flops.
		seq_next.pready = setup;
		seq_next.pslverr = 1'h0;
		seq_next.prdata = '0;
		if (setup) begin
			case (paddr)
				aos_pkg::OFF_CTRL: begin
					seq_next.prdata[aos_pkg::CTRL_EN_BIT] = seq_reg.port_en;
				end
				aos_pkg::OFF_STATUS: begin
					seq_next.prdata[aos_pkg::ST_STATE_LSB +: 3] = seq_reg.state;
					seq_next.prdata[aos_pkg::ST_SGL_BIT] = seq_reg.single_ended_select;
					seq_next.prdata[aos_pkg::ST_ODD_BIT] = seq_reg.odd_sign;
					seq_next.prdata[aos_pkg::ST_ORDER_BIT] = seq_reg.bit_order_select;
					seq_next.prdata[aos_pkg::ST_UNDERRUN_BIT] = seq_reg.underrun;
				end
				aos_pkg::OFF_RESULT: begin
					seq_next.prdata[aos_pkg::RES_BITS-1:0] = seq_reg.last_word;
				end
				default: begin
					seq_next.pslverr = 1'h1;
				end
			endcase
		end
		if (access && pwrite) begin
			if (paddr == aos_pkg::OFF_CTRL) begin
				seq_next.port_en = pwdata[aos_pkg::CTRL_EN_BIT];
			end
			if ((paddr == aos_pkg::OFF_STATUS) && pwdata[aos_pkg::ST_UNDERRUN_BIT]) begin
				seq_next.underrun = 1'h0;
			end
		end

		if (s_sel_n || !seq_reg.port_en) begin
			// Deselected or port disabled: pin activity is ignored and the line is released.
			seq_next.state = aos_pkg::ST_IDLE;
			seq_next.cnt = '0;
			seq_next.doe = 1'h0;
			seq_next.dout = 1'h0;
			seq_next.win = 1'h0;
			seq_next.hold = 1'h0;
			seq_next.comp_pwr = 1'h0;
		end else begin
			case (seq_reg.state)
				aos_pkg::ST_IDLE: begin
					seq_next.state = aos_pkg::ST_START;
				end
				aos_pkg::ST_START: begin
					if (rise && s_din) begin
						seq_next.state = aos_pkg::ST_CFG;
						seq_next.cnt = '0;
					end
				end
				aos_pkg::ST_CFG: begin
					if (rise && (seq_reg.cnt != aos_pkg::CFG_DONE)) begin
						case (seq_reg.cnt)
							aos_pkg::CFG_IDX_SGL: begin
								seq_next.single_ended_select = s_din;
							end
							aos_pkg::CFG_IDX_ODD: begin
								seq_next.odd_sign = s_din;
								seq_next.win = 1'h1;
							end
							default: begin
								seq_next.bit_order_select = s_din;
							end
						endcase
						seq_next.cnt = 4'(seq_reg.cnt + 4'h1);
					end
					// Fourth falling edge after the start bit: hold, convert, drive null bit.
					if (fall && (seq_reg.cnt == aos_pkg::CFG_DONE)) begin
						seq_next.win = 1'h0;
						seq_next.hold = 1'h1;
						seq_next.comp_pwr = 1'h1;
						seq_next.doe = 1'h1;
						seq_next.dout = 1'h0;
						// Three rows of the input pair table are spelled out; the default arm covers the CH0+/CH1- row.
						case ({seq_reg.single_ended_select, seq_reg.odd_sign})
							2'h3: begin
								seq_next.pos_sel = aos_pkg::MUX_CH1;
								seq_next.neg_sel = aos_pkg::MUX_GND;
							end
							2'h2: begin
								seq_next.pos_sel = aos_pkg::MUX_CH0;
								seq_next.neg_sel = aos_pkg::MUX_GND;
							end
							2'h1: begin
								seq_next.pos_sel = aos_pkg::MUX_CH1;
								seq_next.neg_sel = aos_pkg::MUX_CH0;
							end
							default: begin
								seq_next.pos_sel = aos_pkg::MUX_CH0;
								seq_next.neg_sel = aos_pkg::MUX_CH1;
							end
						endcase
						// An empty buffer converts as code zero and is flagged for software.
						seq_next.word = drain_if.valid ? drain_if.data : '0;
						seq_next.shift = drain_if.valid ? drain_if.data : '0;
						seq_next.pop = drain_if.valid;
						seq_next.cnt = '0;
						seq_next.state = aos_pkg::ST_CONV;
					end
				end
				aos_pkg::ST_CONV: begin
					if (fall) begin
						seq_next.dout = seq_reg.shift[aos_pkg::RES_BITS-1];
						seq_next.shift = {seq_reg.shift[aos_pkg::RES_BITS-2:0], 1'h0};
						seq_next.cnt = 4'(seq_reg.cnt + 4'h1);
						if (seq_reg.cnt == aos_pkg::CONV_LAST) begin
							seq_next.hold = 1'h0;
							seq_next.comp_pwr = 1'h0;
							seq_next.last_word = seq_reg.word;
							seq_next.cnt = '0;
							seq_next.state = seq_reg.bit_order_select ?
								aos_pkg::ST_FILL : aos_pkg::ST_DATA;
						end
					end
				end
				aos_pkg::ST_DATA: begin
					if (fall) begin
						seq_next.dout = seq_reg.word[seq_reg.cnt];
						seq_next.cnt = 4'(seq_reg.cnt + 4'h1);
						if (seq_reg.cnt == aos_pkg::DATA_LAST) begin
							seq_next.state = aos_pkg::ST_FILL;
						end
					end
				end
				aos_pkg::ST_FILL: begin
					if (fall) begin
						seq_next.dout = 1'h0;
					end
				end
				default: begin
					seq_next.state = aos_pkg::ST_IDLE;
				end
			endcase
		end
		// Hardware set is applied last so it wins over a same-cycle software clear.
		if ((seq_reg.state == aos_pkg::ST_CFG) && fall && (seq_reg.cnt == aos_pkg::CFG_DONE)
				&& !drain_if.valid && !s_sel_n && seq_reg.port_en) begin
			seq_next.underrun = 1'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_reg <= '0;
			seq_reg.state <= aos_pkg::ST_IDLE;
			seq_reg.port_en <= aos_pkg::CTRL_EN_RST;
			seq_reg.clk_d <= aos_pkg::PIN_RST[aos_pkg::PIN_CLK];
		end else if (cken) begin
			seq_reg <= seq_next;
		end
	end

	assign prdata = seq_reg.prdata;
	assign pready = seq_reg.pready;
	assign pslverr = seq_reg.pslverr;
	assign data_out = seq_reg.dout;
	assign data_oe = seq_reg.doe;
	assign sample_ready = fill_if.ready;
	assign sample_window = seq_reg.win;
	assign hold = seq_reg.hold;
	assign comparator_power = seq_reg.comp_pwr;
	assign mux_pos_sel = seq_reg.pos_sel;
	assign mux_neg_sel = seq_reg.neg_sel;
endmodule : aos_seq

// ==== logic/aos_stream_if.sv ====
// Valid/ready word stream between the sample buffer and its neighbours.
`timescale 1ns/1ns
interface aos_stream_if;
	aos_pkg::aos_word_t data;
	logic               valid;
	logic               ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : aos_stream_if

// ==== logic/aos_sync.sv ====
// Two-flop synchronisers for the select, shift clock and serial input pins.
`timescale 1ns/1ns
module aos_sync (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       cken,
	input  wire logic [2:0] pin_in,
	output logic      [2:0] pin_sync
);
	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] sync;
	} aos_sync_s;

	aos_sync_s sync_reg;
	aos_sync_s sync_next;

	always_comb begin
		sync_next = sync_reg;
		sync_next.meta = pin_in;
		sync_next.sync = sync_reg.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_reg <= {aos_pkg::PIN_RST, aos_pkg::PIN_RST};
		end else if (cken) begin
			sync_reg <= sync_next;
		end
	end

	assign pin_sync = sync_reg.sync;
endmodule : aos_sync

// ==== tb/aos_host.sv ====
// Host model driving select, shift clock and the shared serial wire.
`timescale 1ns/1ns
module aos_host #(
	// A half period of 84 pclk keeps the shift clock just under the recommended rate.
	parameter int HALF = 84
) (
	input  wire logic pclk,
	input  wire logic data_out,
	input  wire logic data_oe,
	output logic      select_n_shutdown,
	output logic      shift_clk,
	output logic      data_in
);
	logic host_oe = 1'h1;
	logic host_d = 1'h0;
	logic float_q = 1'h0;
	// An undriven wire keeps toggling so stale data can never pass for a real bit.
	always @(posedge pclk) begin
		float_q <= ~float_q;
	end
	assign data_in = host_oe ? host_d : (data_oe ? data_out : float_q);
	initial begin
		select_n_shutdown = 1'h1;
		shift_clk = 1'h0;
	end
	task automatic bit_out(input logic b, input logic last);
		host_d <= b;
		repeat (HALF) @(posedge pclk);
		shift_clk <= 1'h1;
		repeat (2) @(posedge pclk);
		if (last) host_oe <= 1'h0;
		repeat (HALF - 2) @(posedge pclk);
		shift_clk <= 1'h0;
	endtask : bit_out
	task automatic exchange(input logic [2:0] cfg, output logic [29:0] rx);
		select_n_shutdown <= 1'h0;
		host_oe <= 1'h1;
		bit_out(1'h0, 1'h0);
		bit_out(1'h1, 1'h0);
		bit_out(cfg[2], 1'h0);
		bit_out(cfg[1], 1'h0);
		bit_out(cfg[0], 1'h1);
		for (int j = 0; j < 30; j++) begin
			repeat (HALF) @(posedge pclk);
			rx[j] = data_in;
			shift_clk <= 1'h1;
			repeat (HALF) @(posedge pclk);
			shift_clk <= 1'h0;
		end
		repeat (HALF) @(posedge pclk);
		select_n_shutdown <= 1'h1;
		repeat (8) @(posedge pclk);
	endtask : exchange
	task automatic idle_toggle(input int n);
		host_oe <= 1'h1;
		for (int j = 0; j < n; j++) begin
			shift_clk <= ~shift_clk;
			host_d <= 1'(j >> 1);
			repeat (HALF) @(posedge pclk);
		end
	endtask : idle_toggle
endmodule : aos_host

// ==== tb/aos_seq_asserts.sv ====
// Port-level checks of the converter serial port sequencer.
`timescale 1ns/1ns
module aos_seq_asserts (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic [aos_pkg::APB_AW-1:0] paddr,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       select_n_shutdown,
	input wire logic                       shift_clk,
	input wire logic                       data_out,
	input wire logic                       data_oe,
	input wire logic                       sample_window,
	input wire logic                       hold,
	input wire logic                       comparator_power
);
	logic [3:0] sel_hi_cnt;
	logic [4:0] fall_cnt;
	logic       clk_q;
	// Falls are counted on the raw pin, so the count does not depend on the synchroniser lag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_hi_cnt <= 4'h0;
			fall_cnt   <= 5'h0;
			clk_q      <= 1'h0;
		end else begin
			clk_q      <= shift_clk;
			sel_hi_cnt <= !select_n_shutdown ? 4'h0 : sel_hi_cnt + {3'h0, sel_hi_cnt != 4'hF};
			fall_cnt   <= !hold ? 5'h0 : fall_cnt + {4'h0, clk_q & ~shift_clk};
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_window_close;
		sample_window ##1 (!sample_window && !select_n_shutdown);
	endsequence
	sequence s_conv_end;
		$fell(hold) && !select_n_shutdown;
	endsequence
	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_slverr_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
		else $error("error response mismatch");
	a_idle_quiet: assert property (sel_hi_cnt >= 4'h5 |-> !data_oe && !hold && !sample_window)
		else $error("activity while deselected");
	a_power_tracks: assert property (comparator_power == hold)
		else $error("comparator power differs from hold");
	a_window_hold: assert property (s_window_close |-> hold)
		else $error("window closed without hold");
	a_null_first: assert property ($rose(data_oe) |-> $rose(hold) && !data_out)
		else $error("line taken without null bit");
	a_conv_twelve: assert property (s_conv_end |-> fall_cnt == 5'h0C)
		else $error("conversion not twelve clocks");
	a_release_bound: assert property ($rose(select_n_shutdown) |-> ##[1:6] !data_oe)
		else $error("line not released");
	a_oe_until_sel: assert property ($fell(data_oe) |-> sel_hi_cnt != 4'h0)
		else $error("line dropped while selected");
endmodule : aos_seq_asserts
bind aos_seq aos_seq_asserts i_aos_seq_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.select_n_shutdown(select_n_shutdown), .shift_clk(shift_clk), .data_out(data_out),
	.data_oe(data_oe), .sample_window(sample_window), .hold(hold),
	.comparator_power(comparator_power));

// ==== tb/tb.sv ====
// Self-checking bench of the converter serial port sequencer.
`timescale 1ns/1ns
module tb;
	logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [aos_pkg::APB_AW-1:0] paddr;
	logic [31:0]                pwdata, prdata, rd;
	logic                       select_n_shutdown, shift_clk, data_in, data_out, data_oe;
	logic                       sample_valid, sample_ready, sample_window, hold, comparator_power;
	logic [1:0]                 mux_pos_sel, mux_neg_sel;
	aos_pkg::aos_word_t         sample_data;
	aos_pkg::aos_word_t         words [4];
	logic [2:0]                 cfgs [4];
	logic [29:0]                rx;
	int                         error_cnt, cmp_count, k;
	aos_seq i_aos_seq (.pclk(pclk), .presetn(presetn), .cken(1'h1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .select_n_shutdown(select_n_shutdown),
		.shift_clk(shift_clk), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
		.sample_window(sample_window), .hold(hold), .comparator_power(comparator_power),
		.mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel));
	aos_host i_aos_host (.pclk(pclk), .data_out(data_out), .data_oe(data_oe),
		.select_n_shutdown(select_n_shutdown), .shift_clk(shift_clk), .data_in(data_in));
	initial pclk = 1'h0;
	always #25 pclk = ~pclk;
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task give_verdict;
		if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : give_verdict
	task automatic wait_for(ref logic s);
		int n;
		for (n = 0; n < 2000; n++) begin
			@(posedge pclk);
			if (s === 1'h1) break;
		end
		if (n == 2000) begin
			error_cnt++;
			give_verdict();
		end
	endtask : wait_for
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		wait_for(pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task push(input aos_pkg::aos_word_t w);
		@(posedge pclk);
		sample_valid <= 1'h1;
		sample_data <= w;
		wait_for(sample_ready);
		sample_valid <= 1'h0;
	endtask : push
	task watch_mux(input logic [2:0] c);
		wait_for(hold);
		@(posedge pclk);
		check({30'h0, mux_pos_sel}, {30'h0, c[1] ? aos_pkg::MUX_CH1 : aos_pkg::MUX_CH0});
		check({30'h0, mux_neg_sel}, {30'h0, c[2] ? aos_pkg::MUX_GND :
			(c[1] ? aos_pkg::MUX_CH0 : aos_pkg::MUX_CH1)});
	endtask : watch_mux
	task frame(input aos_pkg::aos_word_t w, input logic [2:0] c);
		logic [29:0] ex;
		for (int i = 0; i < 30; i++) begin
			ex[i] = (i >= 1 && i <= 12) ? w[12 - i] : (i >= 13 && i <= 24 && !c[0]) ? w[i - 13] : 1'h0;
		end
		fork
			i_aos_host.exchange(c, rx);
			watch_mux(c);
		join
		check({2'h0, rx}, {2'h0, ex});
	endtask : frame
	initial begin
		repeat (100000) @(posedge pclk);
		error_cnt++;
		give_verdict();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, sample_valid, sample_data} = '0;
		error_cnt = 0;
		cmp_count = 0;
		words = '{12'hFFF, 12'h001, 12'hA5C, 12'h3F1};
		cfgs = '{3'h5, 3'h6, 3'h1, 3'h2};
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		repeat (3) @(posedge pclk);
		apb(1'h0, aos_pkg::OFF_CTRL, 32'h0);
		check(rd, 32'h1);
		apb(1'h0, 8'h0C, 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'h1, aos_pkg::OFF_CTRL, 32'h1);
		i_aos_host.idle_toggle(16);
		apb(1'h0, aos_pkg::OFF_STATUS, 32'h0);
		check({29'h0, rd[2:0]}, 32'h0);
		for (k = 0; k < 4; k += 2) begin
			push(words[k]);
			push(words[k + 1]);
			@(posedge pclk);
			check({31'h0, sample_ready}, 32'h0);
			frame(words[k], cfgs[k]);
			frame(words[k + 1], cfgs[k + 1]);
			apb(1'h0, aos_pkg::OFF_RESULT, 32'h0);
			check(rd, {20'h0, words[k + 1]});
		end
		// The buffer is empty now, so this frame must send a zero word.
		frame(12'h000, 3'h5);
		apb(1'h0, aos_pkg::OFF_STATUS, 32'h0);
		check({25'h0, rd[7:4], rd[2:0]}, 32'h68);
		apb(1'h1, aos_pkg::OFF_STATUS, 32'h80);
		apb(1'h0, aos_pkg::OFF_STATUS, 32'h0);
		check({25'h0, rd[7:4], rd[2:0]}, 32'h28);
		apb(1'h1, aos_pkg::OFF_CTRL, 32'h0);
		apb(1'h0, aos_pkg::OFF_CTRL, 32'h0);
		check(rd, 32'h0);
		// A disabled port must ignore a whole frame, so no underrun is flagged.
		i_aos_host.exchange(3'h5, rx);
		apb(1'h0, aos_pkg::OFF_STATUS, 32'h0);
		check({25'h0, rd[7:4], rd[2:0]}, 32'h28);
		give_verdict();
	end
endmodule : tb
